// ---- hw/rx_power_pkg.sv ----
// Purpose: shared constants and types for the receiver power and timing pulse control
// Assumes: 25 MHz system clock, 32-bit register bus
// Notes: command word layout is op in [7:0], argument in [15:8], checksum in [23:16]
package rx_power_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int SEC_MS = 1000;
	localparam int PULSE_MS = 100;
	localparam int SEC_CYCLES = CLK_HZ / 1000 * SEC_MS / 1000;
	localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS / 1000;
	localparam int RTC_HZ = 32768;
	localparam int TONE_SLOTS = 12;
	localparam int LOG_BYTES = 128 * 1024;
	localparam int LOG_WORDS = LOG_BYTES / 4;
	localparam int LOG_AW = 15;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PERIOD = 8'h0c;
	localparam logic [7:0] OFS_LOG_CFG = 8'h10;
	localparam logic [7:0] OFS_LOG_COUNT = 8'h14;
	localparam logic [7:0] OFS_LOG_DATA = 8'h18;
	localparam logic [7:0] OFS_RTC = 8'h1c;
	localparam logic [7:0] OFS_RX_DATA = 8'h20;
	// command opcodes
	localparam logic [7:0] OP_LOW_POWER = 8'h01;
	localparam logic [7:0] OP_STANDBY = 8'h02;
	localparam logic [7:0] OP_PERIODIC = 8'h03;
	localparam logic [7:0] OP_ADAPTIVE = 8'h04;
	localparam logic [7:0] OP_LOG_START = 8'h05;
	localparam logic [7:0] OP_LOG_STOP = 8'h06;
	localparam logic [7:0] OP_LOG_ERASE = 8'h07;
	localparam logic [7:0] OP_LOG_READ = 8'h08;
	localparam logic [7:0] OP_AUGMENT = 8'h09;
	localparam logic [7:0] OP_PULSE_MODE = 8'h0a;
	localparam logic [7:0] OP_BAUD = 8'h0b;
	localparam logic [7:0] OP_CANCELLER = 8'h0c;
	localparam logic [7:0] STANDBY_CHECKSUM = 8'h28;
	// reset values
	localparam logic [3:0] LOG_INTERVAL_RST = 4'hf;
	localparam logic [15:0] ON_TIME_RST = 16'h0005;
	localparam logic [15:0] OFF_TIME_RST = 16'h000a;
	localparam logic [2:0] BAUD_RST = 3'h0;
	// timing pulse arming modes
	localparam logic [1:0] PULSE_ON_3D = 2'h0;
	localparam logic [1:0] PULSE_ON_2D = 2'h1;
	localparam logic [1:0] PULSE_AT_POWER_UP = 2'h2;
	// log trigger selection
	localparam logic [1:0] TRIG_NOW = 2'h0;
	localparam logic [1:0] TRIG_FIX = 2'h1;
	localparam logic [1:0] TRIG_MOTION = 2'h2;
	localparam logic [1:0] TRIG_2D = 2'h3;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_STANDBY = 4'b0010,
		ST_PER_ON = 4'b0100,
		ST_PER_OFF = 4'b1000
	} power_state_t;

	typedef struct packed {
		logic [7:0] spare;
		logic [7:0] checksum;
		logic [7:0] arg;
		logic [7:0] op;
	} cmd_word_t;

	// bit period of the serial link for a rate selection
	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h1: rate = 19200;
			3'h2: rate = 38400;
			3'h3: rate = 57600;
			3'h4: rate = 115200;
			default: rate = 9600;
		endcase
		baud_div = 16'(CLK_HZ / rate);
	endfunction
endpackage

// ---- hw/receiver_power_pps_control.sv ----
// Function
// R1: low-power mode on at reset; low-power command with argument 0 turns it off.
// R2: low-power mode never lowers the once-per-second position request.
// R3: standby command with argument 0 and checksum 28 puts RF and processor asleep.
// R4: any received serial byte ends standby and resumes normal operation.
// R5: periodic and adaptive modes accepted only while low-power mode is off.
// R6: periodic mode cycles engine on and off in programmed on and off slots.
// R7: adaptive mode adjusts slots, stays fully on under poor reception or motion.
// R8: timing pulse by default starts after a 3D fix, aligned to navigation second.
// R9: timing pulse lasts 100 ms and repeats every second; default counts give 2500 cycles every 25000 cycles (100 us per 1 ms at 25 MHz).
// R10: option arms the timing pulse after a 2D fix or right after power-up.
// R11: logger stores records by itself into an internal 128kB memory.
// R12: logger takes start, stop, erase and readout commands.
// R13: log interval programmable from 15 seconds down to one second; default counts give 15 ms down to 1 ms (ticks of 25000 cycles).
// R14: logging starts on a selectable trigger event.
// R15: tone canceller on by default, handles up to 12 tones.
// R16: augmentation tracking on by default, turned off by command.
// R17: augmentation forced off while low-power mode is on.
// R18: real-time clock counts 32,768 Hz crystal ticks while backup power holds.
// R19: stored orbit data allows fast start once coarse time is known.
// R20: serial link defaults to 9600 baud, 8 data bits, one stop, no parity.
// R21: baud command switches the serial link to a higher rate.
// R22: characters framed with low start bit, data LSB first, stop bit, idle high.
//
// Purpose: power mode, timing pulse, logger and serial wake control of a positioning receiver
// Assumes: navigation engine inputs are on i_clk; serial and crystal inputs are asynchronous
// Notes: APB slave with zero wait states; read data is captured in the setup cycle
`timescale 1ns/10ps
module receiver_power_pps_control import rx_power_pkg::*; #(
	parameter int SEC_COUNT = SEC_CYCLES,
	parameter int PULSE_COUNT = PULSE_CYCLES
) (
	input wire logic i_clk, // system clock
	input wire logic i_reset_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic i_serial_rx, // serial line from host
	input wire logic i_rtc_xtal, // 32,768 Hz crystal clock
	input wire logic i_nav_second, // navigation second boundary pulse
	input wire logic i_fix_3d, // 3D fix held
	input wire logic i_fix_2d, // 2D fix held
	input wire logic i_poor_signal, // reception poor
	input wire logic i_moving, // motion detected
	input wire logic i_orbit_saved, // orbit data stored pulse
	input wire logic [31:0] i_position, // position record
	output logic o_rf_sleep, // RF frontend in deep sleep
	output logic o_cpu_sleep, // processor in deep sleep
	output logic o_engine_on, // engine powered
	output logic o_fix_req, // position request pulse
	output logic o_dynamic_low_power_mode, // low-power mode on
	output logic o_augment_en, // augmentation tracking on
	output logic o_tone_interference_canceller, // canceller on
	output logic [3:0] o_tone_slots, // canceller tone capacity
	output logic o_second_timing_pulse, // timing pulse
	output logic o_fast_start_ok // hot start possible
);
	power_state_t state_ff;
	cmd_word_t cmd;
	logic ulp_ff, augment_ff, aic_ff, adaptive_ff, pulse_armed_ff, pulse_ff;
	logic [1:0] pulse_mode_ff, log_trig_ff;
	logic [2:0] baud_ff;
	logic [15:0] on_time_ff, off_time_ff, slot_cnt_ff;
	logic [31:0] sec_cnt_ff, pulse_cnt_ff, prdata_ff, rtc_sec_ff;
	logic sec_tick;
	logic [3:0] log_int_ff, log_cnt_ff;
	logic log_arm_ff, log_run_ff;
	logic [LOG_AW:0] log_wr_ff;
	logic [LOG_AW-1:0] log_rd_ff;
	logic [31:0] log_mem [LOG_WORDS];
	logic rx_s1_ff, rx_s2_ff, rx_busy_ff, rx_done, rx_valid_ff;
	logic [15:0] rx_cnt_ff;
	logic [3:0] rx_bit_ff;
	logic [7:0] rx_shift_ff, rx_data_ff;
	logic xt_s1_ff, xt_s2_ff, xt_d_ff, rtc_run_ff, orbit_ff;
	logic [14:0] rtc_frac_ff;
	logic wr_en, rd_en, cmd_wr, mapped;

	// bus decode
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign cmd = cmd_word_t'(pwdata);
	assign cmd_wr = wr_en & (paddr == OFS_CMD);
	always_comb begin
		unique case (paddr)
			OFS_CTRL, OFS_CMD, OFS_STATUS, OFS_PERIOD, OFS_LOG_CFG,
			OFS_LOG_COUNT, OFS_LOG_DATA, OFS_RTC, OFS_RX_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_ff;

	// read data captured in the setup cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prdata_ff <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			unique case (paddr)
				OFS_CTRL: prdata_ff <= {19'h0, baud_ff, pulse_mode_ff, adaptive_ff, aic_ff, augment_ff, ulp_ff,
					4'(TONE_SLOTS)};
				OFS_STATUS: prdata_ff <= {20'h0, rx_valid_ff, o_fast_start_ok, rtc_run_ff, log_wr_ff[LOG_AW],
					log_run_ff, log_arm_ff, pulse_ff, pulse_armed_ff, state_ff};
				OFS_PERIOD: prdata_ff <= {off_time_ff, on_time_ff};
				OFS_LOG_CFG: prdata_ff <= {26'h0, log_trig_ff, log_int_ff};
				OFS_LOG_COUNT: prdata_ff <= {{(31 - LOG_AW){1'b0}}, log_wr_ff};
				OFS_LOG_DATA: prdata_ff <= log_mem[log_rd_ff];
				OFS_RTC: prdata_ff <= rtc_sec_ff;
				OFS_RX_DATA: prdata_ff <= {24'h0, rx_data_ff};
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	// mode and default settings
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ulp_ff <= 1'b1; // see R1
			augment_ff <= 1'b1; // see R16
			aic_ff <= 1'b1; // see R15
			pulse_mode_ff <= PULSE_ON_3D; // see R8
			baud_ff <= BAUD_RST; // see R20
		end else if (cmd_wr) begin
			unique case (cmd.op)
				OP_LOW_POWER: ulp_ff <= (cmd.arg != 8'h0); // see R1
				OP_AUGMENT: augment_ff <= (cmd.arg != 8'h0); // see R16
				OP_CANCELLER: aic_ff <= (cmd.arg != 8'h0);
				OP_PULSE_MODE: pulse_mode_ff <= cmd.arg[1:0]; // see R10
				OP_BAUD: baud_ff <= cmd.arg[2:0]; // see R21
				default: ;
			endcase
		end
	end

	// periodic slot settings
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			on_time_ff <= ON_TIME_RST;
			off_time_ff <= OFF_TIME_RST;
		end else if (wr_en && paddr == OFS_PERIOD) begin
			on_time_ff <= pwdata[15:0]; // see R6
			off_time_ff <= pwdata[31:16];
		end
	end

	// second divider, realigned to the navigation second
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sec_cnt_ff <= 32'h0;
		end else if (i_nav_second || sec_cnt_ff == 32'(SEC_COUNT - 1)) begin
			sec_cnt_ff <= 32'h0;
		end else begin
			sec_cnt_ff <= sec_cnt_ff + 32'h1;
		end
	end
	assign sec_tick = (sec_cnt_ff == 32'(SEC_COUNT - 1)) | i_nav_second;

	// power state machine
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= ST_ACTIVE;
			adaptive_ff <= 1'b0;
			slot_cnt_ff <= 16'h0;
		end else begin
			unique case (state_ff)
				ST_ACTIVE: begin
					if (cmd_wr && cmd.op == OP_STANDBY && cmd.arg == 8'h0 && cmd.checksum == STANDBY_CHECKSUM) begin
						state_ff <= ST_STANDBY; // see R3
					end else if (cmd_wr && (cmd.op == OP_PERIODIC || cmd.op == OP_ADAPTIVE) && cmd.arg != 8'h0
						&& !ulp_ff) begin
						state_ff <= ST_PER_ON; // see R5
						adaptive_ff <= (cmd.op == OP_ADAPTIVE);
						slot_cnt_ff <= 16'h0;
					end
				end
				ST_STANDBY: begin
					if (rx_done) begin
						state_ff <= ST_ACTIVE; // see R4
					end
				end
				ST_PER_ON, ST_PER_OFF: begin
					if (cmd_wr && (cmd.op == OP_PERIODIC || cmd.op == OP_ADAPTIVE) && cmd.arg == 8'h0) begin
						state_ff <= ST_ACTIVE;
						adaptive_ff <= 1'b0;
					end else if (adaptive_ff && (i_poor_signal || i_moving)) begin
						state_ff <= ST_PER_ON; // see R7
						slot_cnt_ff <= 16'h0;
					end else if (sec_tick) begin
						if (state_ff == ST_PER_ON && slot_cnt_ff + 16'h1 >= on_time_ff) begin
							state_ff <= ST_PER_OFF; // see R6
							slot_cnt_ff <= 16'h0;
						end else if (state_ff == ST_PER_OFF && slot_cnt_ff + 16'h1 >= off_time_ff) begin
							state_ff <= ST_PER_ON;
							slot_cnt_ff <= 16'h0;
						end else begin
							slot_cnt_ff <= slot_cnt_ff + 16'h1;
						end
					end
				end
			endcase
		end
	end

	// power outputs
	assign o_rf_sleep = (state_ff == ST_STANDBY) | (state_ff == ST_PER_OFF); // see R3
	assign o_cpu_sleep = (state_ff == ST_STANDBY) | (state_ff == ST_PER_OFF);
	assign o_engine_on = (state_ff == ST_ACTIVE) | (state_ff == ST_PER_ON);
	assign o_fix_req = sec_tick & o_engine_on; // see R2
	assign o_dynamic_low_power_mode = ulp_ff;
	assign o_augment_en = augment_ff & ~ulp_ff; // see R17
	assign o_tone_interference_canceller = aic_ff;
	assign o_tone_slots = 4'(TONE_SLOTS); // see R15

	// timing pulse arming and width
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pulse_armed_ff <= 1'b0;
			pulse_ff <= 1'b0;
			pulse_cnt_ff <= 32'h0;
		end else begin
			unique case (pulse_mode_ff)
				PULSE_ON_2D: pulse_armed_ff <= i_fix_2d | i_fix_3d; // see R10
				PULSE_AT_POWER_UP: pulse_armed_ff <= 1'b1;
				default: pulse_armed_ff <= i_fix_3d; // see R8
			endcase
			if (sec_tick && pulse_armed_ff && o_engine_on) begin
				pulse_ff <= 1'b1; // see R8
				pulse_cnt_ff <= 32'h0;
			end else if (pulse_ff && pulse_cnt_ff == 32'(PULSE_COUNT - 1)) begin
				pulse_ff <= 1'b0; // see R9
			end else if (pulse_ff) begin
				pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
			end
		end
	end
	assign o_second_timing_pulse = pulse_ff;

	// logger configuration
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			log_int_ff <= LOG_INTERVAL_RST;
			log_trig_ff <= TRIG_NOW;
		end else if (wr_en && paddr == OFS_LOG_CFG) begin
			log_int_ff <= (pwdata[3:0] == 4'h0) ? 4'h1 : pwdata[3:0]; // see R13
			log_trig_ff <= pwdata[5:4]; // see R14
		end
	end

	// logger control and record store, full then stop
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			log_arm_ff <= 1'b0;
			log_run_ff <= 1'b0;
			log_cnt_ff <= 4'h0;
			log_wr_ff <= '0;
		end else begin
			if (cmd_wr && cmd.op == OP_LOG_STOP) begin
				log_arm_ff <= 1'b0; // see R12
				log_run_ff <= 1'b0;
			end else if (cmd_wr && cmd.op == OP_LOG_START) begin
				log_arm_ff <= 1'b1;
			end else if (log_arm_ff && !log_run_ff) begin
				unique case (log_trig_ff)
					TRIG_FIX: log_run_ff <= i_fix_3d; // see R14
					TRIG_MOTION: log_run_ff <= i_moving;
					TRIG_2D: log_run_ff <= i_fix_2d | i_fix_3d;
					default: log_run_ff <= 1'b1;
				endcase
				log_cnt_ff <= 4'h0;
			end
			if (cmd_wr && cmd.op == OP_LOG_ERASE) begin
				log_wr_ff <= '0; // see R12
			end else if (log_run_ff && sec_tick && !log_wr_ff[LOG_AW]) begin
				if (log_cnt_ff + 4'h1 >= log_int_ff) begin
					log_cnt_ff <= 4'h0;
					log_wr_ff <= log_wr_ff + 1'b1; // see R11
				end else begin
					log_cnt_ff <= log_cnt_ff + 4'h1;
				end
			end
		end
	end

	// record memory, no reset
	always_ff @(posedge i_clk) begin
		if (log_run_ff && sec_tick && !log_wr_ff[LOG_AW] && log_cnt_ff + 4'h1 >= log_int_ff) begin
			log_mem[log_wr_ff[LOG_AW-1:0]] <= i_position; // see R11
		end
	end

	// readout pointer
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			log_rd_ff <= '0;
		end else if (cmd_wr && cmd.op == OP_LOG_READ) begin
			log_rd_ff <= '0; // see R12
		end else if (rd_en && paddr == OFS_LOG_DATA) begin
			log_rd_ff <= log_rd_ff + 1'b1;
		end
	end

	// serial receiver, 8N1, lsb first
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			rx_busy_ff <= 1'b0;
			rx_cnt_ff <= 16'h0;
			rx_bit_ff <= 4'h0;
			rx_shift_ff <= 8'h0;
			rx_data_ff <= 8'h0;
			rx_done <= 1'b0;
		end else begin
			rx_s1_ff <= i_serial_rx;
			rx_s2_ff <= rx_s1_ff;
			rx_done <= 1'b0;
			if (!rx_busy_ff) begin
				if (!rx_s2_ff) begin
					rx_busy_ff <= 1'b1; // see R22
					rx_cnt_ff <= baud_div(baud_ff) >> 1; // see R21
					rx_bit_ff <= 4'h0;
				end
			end else if (rx_cnt_ff != 16'h0) begin
				rx_cnt_ff <= rx_cnt_ff - 16'h1;
			end else begin
				rx_cnt_ff <= baud_div(baud_ff) - 16'h1;
				rx_bit_ff <= rx_bit_ff + 4'h1;
				if (rx_bit_ff == 4'h0 && rx_s2_ff) begin
					rx_busy_ff <= 1'b0; // false start
				end else if (rx_bit_ff >= 4'h1 && rx_bit_ff <= 4'h8) begin
					rx_shift_ff <= {rx_s2_ff, rx_shift_ff[7:1]}; // see R22
				end else if (rx_bit_ff == 4'h9) begin
					rx_busy_ff <= 1'b0; // see R20
					rx_data_ff <= rx_shift_ff;
					rx_done <= rx_s2_ff;
				end
			end
		end
	end

	// received byte flag, set wins over read clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_valid_ff <= 1'b0;
		end else if (rx_done) begin
			rx_valid_ff <= 1'b1;
		end else if (rd_en && paddr == OFS_RX_DATA) begin
			rx_valid_ff <= 1'b0;
		end
	end

	// real-time clock from crystal edges
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			xt_s1_ff <= 1'b0;
			xt_s2_ff <= 1'b0;
			xt_d_ff <= 1'b0;
			rtc_frac_ff <= 15'h0;
			rtc_sec_ff <= 32'h0;
			rtc_run_ff <= 1'b0;
		end else begin
			xt_s1_ff <= i_rtc_xtal;
			xt_s2_ff <= xt_s1_ff;
			xt_d_ff <= xt_s2_ff;
			if (xt_s2_ff && !xt_d_ff) begin
				rtc_run_ff <= 1'b1;
				if (rtc_frac_ff == 15'(RTC_HZ - 1)) begin
					rtc_frac_ff <= 15'h0; // see R18
					rtc_sec_ff <= rtc_sec_ff + 32'h1;
				end else begin
					rtc_frac_ff <= rtc_frac_ff + 15'h1;
				end
			end
		end
	end

	// stored orbit data flag and fast start
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			orbit_ff <= 1'b0;
		end else if (i_orbit_saved) begin
			orbit_ff <= 1'b1;
		end
	end
	assign o_fast_start_ok = orbit_ff & rtc_run_ff; // see R19
endmodule

// ---- tb/rx_power_chk.sv ----
// Purpose: port-level checks on power modes, standby entry, augmentation and timing pulse
// Assumes: one clock domain, asynchronous active-low reset
// Notes: second and pulse counts come from the bound instance
`timescale 1ns/10ps
module rx_power_chk import rx_power_pkg::*; #(
	parameter int SEC_COUNT = 200,
	parameter int PULSE_COUNT = 20
) (
	input wire logic i_clk, // clock
	input wire logic i_reset_n, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic o_rf_sleep, // rf asleep
	input wire logic o_cpu_sleep, // processor asleep
	input wire logic o_engine_on, // engine powered
	input wire logic o_fix_req, // position request
	input wire logic o_dynamic_low_power_mode, // low power on
	input wire logic o_augment_en, // augmentation on
	input wire logic [3:0] o_tone_slots, // tone capacity
	input wire logic o_second_timing_pulse // timing pulse
);
	logic [31:0] hi_cnt_ff;
	logic [31:0] gap_cnt_ff;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// cycles the timing pulse has been high
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			hi_cnt_ff <= '0;
		else
			hi_cnt_ff <= o_second_timing_pulse ? hi_cnt_ff + 1 : '0;
	end
	// cycles since the last position request while powered
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			gap_cnt_ff <= '0;
		else
			gap_cnt_ff <= (o_fix_req || !o_engine_on) ? '0 : gap_cnt_ff + 1;
	end
	// command word write with op and argument
	sequence cmd_wr(logic [7:0] op, logic [7:0] arg);
		psel && penable && pwrite && paddr == OFS_CMD && pwdata[15:0] == {arg, op};
	endsequence
	sequence standby_ok;
		cmd_wr(OP_STANDBY, 8'h00) ##0 (pwdata[23:16] == STANDBY_CHECKSUM);
	endsequence
	sequence standby_bad;
		cmd_wr(OP_STANDBY, 8'h00) ##0 (pwdata[23:16] != STANDBY_CHECKSUM && o_engine_on);
	endsequence
	lp_aug_a: assert property (o_dynamic_low_power_mode |-> !o_augment_en)
		else $error("augmentation on in low power mode");
	lp_off_a: assert property (cmd_wr(OP_LOW_POWER, 8'h00) |=> !o_dynamic_low_power_mode)
		else $error("low power mode not turned off");
	aug_off_a: assert property (cmd_wr(OP_AUGMENT, 8'h00) |=> !o_augment_en)
		else $error("augmentation not turned off");
	standby_in_a: assert property (standby_ok |=> o_rf_sleep && o_cpu_sleep && !o_engine_on)
		else $error("standby not entered");
	standby_bad_a: assert property (standby_bad |=> !o_rf_sleep)
		else $error("standby entered on wrong checksum");
	sleep_pair_a: assert property (o_rf_sleep == o_cpu_sleep && o_engine_on != o_rf_sleep)
		else $error("sleep outputs disagree");
	pulse_width_a: assert property ($fell(o_second_timing_pulse) |-> hi_cnt_ff == PULSE_COUNT)
		else $error("timing pulse width wrong");
	fix_gap_a: assert property (o_engine_on |-> gap_cnt_ff <= SEC_COUNT + 2)
		else $error("position request missed a second");
	fix_pulse_a: assert property (o_fix_req |-> o_engine_on ##1 !o_fix_req)
		else $error("position request not a single pulse");
	tone_cap_a: assert property (o_tone_slots == 4'hc)
		else $error("tone capacity wrong");
endmodule

bind receiver_power_pps_control rx_power_chk #(.SEC_COUNT(SEC_COUNT), .PULSE_COUNT(PULSE_COUNT)) u_rx_power_chk (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .o_rf_sleep(o_rf_sleep), .o_cpu_sleep(o_cpu_sleep),
	.o_engine_on(o_engine_on), .o_fix_req(o_fix_req), .o_dynamic_low_power_mode(o_dynamic_low_power_mode),
	.o_augment_en(o_augment_en), .o_tone_slots(o_tone_slots), .o_second_timing_pulse(o_second_timing_pulse));

// ---- tb/host_serial_model.sv ----
// Purpose: host end of the serial command link
// Assumes: default rate, 8 data bits, one stop bit, no parity
// Notes: line idles high between characters
`timescale 1ns/10ps
module host_serial_model import rx_power_pkg::*; (
	input wire logic i_clk, // system clock
	output logic o_tx // serial line to the device
);
	localparam int BIT_CYCLES = CLK_HZ / 9600;
	// idle level
	initial begin
		o_tx = 1'b1;
	end
	// one character: start low, data lsb first, stop high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge i_clk);
			o_tx <= frame[i];
			repeat (BIT_CYCLES - 1) @(posedge i_clk);
		end
	endtask
endmodule

// ---- tb/receiver_power_pps_control_tb.sv ----
// Purpose: self-checking bench for power modes, wake, timing pulse and logger
// Assumes: short second and pulse counts to keep the run brief
// Notes: apb master waits on pready; crystal stand-in toggles every 381 cycles
`timescale 1ns/10ps
module receiver_power_pps_control_tb import rx_power_pkg::*;;
	localparam int SEC = 200;
	localparam int PUL = 20;
	localparam int CEIL = 40000;
	// {expected ctrl, arg, op}
	localparam logic [31:0] ROWS [14] = '{
		{16'h006c, 8'h00, OP_LOW_POWER}, {16'h004c, 8'h00, OP_AUGMENT}, {16'h006c, 8'h01, OP_AUGMENT},
		{16'h002c, 8'h00, OP_CANCELLER}, {16'h006c, 8'h01, OP_CANCELLER}, {16'h016c, 8'h01, OP_PULSE_MODE},
		{16'h026c, 8'h02, OP_PULSE_MODE}, {16'h006c, 8'h00, OP_PULSE_MODE}, {16'h046c, 8'h01, OP_BAUD},
		{16'h086c, 8'h02, OP_BAUD}, {16'h0c6c, 8'h03, OP_BAUD}, {16'h106c, 8'h04, OP_BAUD},
		{16'h006c, 8'h00, OP_BAUD}, {16'h007c, 8'h01, OP_LOW_POWER}};
	logic i_clk, i_reset_n, psel, penable, pwrite, pready, pslverr, serial_line, rtc_xtal;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic i_nav_second, i_fix_3d, err, o_rf_sleep, o_cpu_sleep, o_engine_on, lp_mode, aug_en, canc_en, pulse;
	logic [3:0] tone_slots;
	logic moving, orbit_saved, fast_ok;
	int n_errors, cmp_count, cycles, n;
	receiver_power_pps_control #(.SEC_COUNT(SEC), .PULSE_COUNT(PUL)) u_receiver_power_pps_control (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.i_serial_rx(serial_line), .i_rtc_xtal(rtc_xtal), .i_nav_second(i_nav_second), .i_fix_3d(i_fix_3d),
		.i_fix_2d(1'b0), .i_poor_signal(1'b0), .i_moving(moving), .i_orbit_saved(orbit_saved),
		.i_position(32'h12345678), .o_rf_sleep(o_rf_sleep), .o_cpu_sleep(o_cpu_sleep),
		.o_engine_on(o_engine_on), .o_fix_req(), .o_dynamic_low_power_mode(lp_mode), .o_augment_en(aug_en),
		.o_tone_interference_canceller(canc_en), .o_tone_slots(tone_slots),
		.o_second_timing_pulse(pulse), .o_fast_start_ok(fast_ok));
	host_serial_model u_host_serial_model (.i_clk(i_clk), .o_tx(serial_line));
	// clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// cycle count, crystal stand-in, hang guard
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles % 381 == 0)
			rtc_xtal <= ~rtc_xtal;
		if (cycles == CEIL) begin
			n_errors++;
			close_out;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input logic [7:0] ck);
		apb(1'b1, OFS_CMD, {8'h00, ck, arg, op});
	endtask
	task automatic settle;
		@(posedge i_clk);
		#1;
	endtask
	task automatic wait_sig(input bit use_pulse, input logic lvl, input int lim);
		int k = 0;
		while ((use_pulse ? pulse : o_engine_on) !== lvl && k < lim) begin
			@(posedge i_clk);
			k++;
		end
		chk({31'h0, k < lim}, 32'h1);
	endtask
	task automatic done(input string s);
		$display("test %s ended, mismatches so far %0d", s, n_errors);
	endtask
	task automatic close_out;
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{i_reset_n, psel, penable, pwrite, rtc_xtal, i_nav_second, i_fix_3d, moving, orbit_saved} = 9'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		settle;
		chk({22'h0, lp_mode, canc_en, aug_en, o_engine_on, o_rf_sleep, pulse, tone_slots}, 32'h34c);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0000007c);
		apb(1'b0, OFS_PERIOD, 32'h0);
		chk(rd, 32'h000a0005);
		apb(1'b0, OFS_LOG_CFG, 32'h0);
		chk(rd, 32'h0000000f);
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, err}, 32'h1);
		done("reset");
		foreach (ROWS[i]) begin
			cmd(ROWS[i][7:0], ROWS[i][15:8], 8'h00);
			apb(1'b0, OFS_CTRL, 32'h0);
			settle;
			chk(rd, {16'h0, ROWS[i][31:16]});
			chk({29'h0, lp_mode, aug_en, canc_en}, {29'h0, ROWS[i][20], ROWS[i][21] & ~ROWS[i][20], ROWS[i][22]});
		end
		done("commands");
		cmd(OP_STANDBY, 8'h00, 8'h29);
		settle;
		chk({31'h0, o_rf_sleep}, 32'h0);
		cmd(OP_STANDBY, 8'h00, STANDBY_CHECKSUM);
		settle;
		chk({30'h0, o_rf_sleep, o_cpu_sleep}, 32'h3);
		u_host_serial_model.send_byte(8'ha5);
		wait_sig(1'b0, 1'b1, 2000);
		apb(1'b0, OFS_RX_DATA, 32'h0);
		chk(rd, 32'h000000a5);
		done("standby");
		cmd(OP_PERIODIC, 8'h01, 8'h00);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h1);
		cmd(OP_LOW_POWER, 8'h00, 8'h00);
		apb(1'b1, OFS_PERIOD, 32'h00010001);
		cmd(OP_PERIODIC, 8'h01, 8'h00);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h4);
		wait_sig(1'b0, 1'b0, 2 * SEC + 5);
		chk({31'h0, o_rf_sleep}, 32'h1);
		wait_sig(1'b0, 1'b1, 2 * SEC + 5);
		cmd(OP_PERIODIC, 8'h00, 8'h00);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h1);
		// adaptive mode held fully on while moving
		cmd(OP_ADAPTIVE, 8'h01, 8'h00);
		wait_sig(1'b0, 1'b0, 2 * SEC + 5);
		@(posedge i_clk) moving <= 1'b1;
		@(posedge i_clk);
		n = 0;
		repeat (2 * SEC) begin
			@(posedge i_clk);
			if (o_engine_on !== 1'b1)
				n++;
		end
		chk(n, 0);
		moving <= 1'b0;
		cmd(OP_ADAPTIVE, 8'h00, 8'h00);
		done("periodic");
		n = 0;
		repeat (2 * SEC) begin
			@(posedge i_clk);
			if (pulse !== 1'b0)
				n++;
		end
		chk(n, 0);
		@(posedge i_clk) i_fix_3d <= 1'b1;
		wait_sig(1'b1, 1'b1, SEC + 5);
		n = 0;
		while (pulse === 1'b1 && n < SEC) begin
			@(posedge i_clk);
			n++;
		end
		chk(n, PUL);
		@(posedge i_clk) i_nav_second <= 1'b1;
		@(posedge i_clk) i_nav_second <= 1'b0;
		wait_sig(1'b1, 1'b1, 3);
		done("pulse");
		apb(1'b1, OFS_LOG_CFG, 32'h0);
		apb(1'b0, OFS_LOG_CFG, 32'h0);
		chk(rd, 32'h00000001);
		cmd(OP_LOG_START, 8'h00, 8'h00);
		repeat (3 * SEC) @(posedge i_clk);
		cmd(OP_LOG_STOP, 8'h00, 8'h00);
		apb(1'b0, OFS_LOG_COUNT, 32'h0);
		chk({31'h0, rd >= 2 && rd <= 4}, 32'h1);
		cmd(OP_LOG_READ, 8'h00, 8'h00);
		apb(1'b0, OFS_LOG_DATA, 32'h0);
		chk(rd, 32'h12345678);
		cmd(OP_LOG_ERASE, 8'h00, 8'h00);
		apb(1'b0, OFS_LOG_COUNT, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, fast_ok}, 32'h0);
		@(posedge i_clk) orbit_saved <= 1'b1;
		@(posedge i_clk) orbit_saved <= 1'b0;
		settle;
		chk({31'h0, fast_ok}, 32'h1);
		done("logger");
		close_out;
	end
endmodule
